// *** oscillator_switch_and_fail_monitor.sv ***
`timescale 1ns/1ps

// What this block does
// R1: Secondary crystal stays on, even asleep, when kept on
// R2: Secondary drives clock only in group 00, kept on
// R3: PLL gain selectable four, eight or sixteen
// R4: Lock indication follows PLL lock and loss
// R5: Lock status readable in control bit 5
// R6: Group 01 runs from fast internal RC
// R7: Four-bit signed fast RC trim, 1.5% steps
// R8: Slow internal RC always on at power-on
// R9: After power-up delay slow RC on only if needed
// R10: Monitor enabled keeps slow RC on except Sleep
// R11: Failure traps, selects fast RC, flags, clears request
// R12: Watchdog keeps slow RC clock through failure
// R13: Oscillator not started at delay end traps too
// R14: Switch among four groups, primary mode by configuration
// R15: Current group read-only, next writable, both reset-loaded
// R16: Request bit starts switch, clearing it aborts
// R17: Configuration 1x disables switching and monitor
// R18: Switching disabled, configuration alone selects clock
// R19: Software avoids clocks below 100 KHz with monitor
// R20: Low byte unlocked by 46 then 57
// R21: High byte unlocked by 78 then 9A
// R22: Broken sequences discarded, locked writes ignored
module oscillator_switch_and_fail_monitor (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Configuration bits, static after power-up
  input wire logic [1:0] i_reset_group_cfg,
  input wire logic [3:0] i_primary_mode_cfg,
  input wire logic [1:0] i_switch_monitor_cfg,
  input wire logic i_watchdog_cfg_enable,
  // Core state
  input wire logic i_sleep,
  input wire logic i_soft_watchdog_enable,
  // Oscillator side, asynchronous
  input wire logic i_clock_fail,
  input wire logic i_pll_lock,
  input wire logic i_osc_ready,
  input wire logic i_power_up_done,
  // Oscillator controls
  output logic o_secondary_osc_on,
  output logic o_use_secondary,
  output logic [1:0] o_clock_group,
  output logic [3:0] o_primary_mode,
  output logic o_pll_enable,
  output osc_switch_pkg::pll_gain_t o_pll_gain,
  output logic o_pll_locked,
  output logic o_fast_rc_on,
  output logic [3:0] o_fast_rc_trim,
  output logic o_slow_rc_on,
  output logic o_fail_trap
);

  localparam int SYNC_FAIL = 0;
  localparam int SYNC_LOCK = 1;
  localparam int SYNC_READY = 2;
  localparam int SYNC_POWER_UP = 3;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [1:0] reset_group;
    logic [3:0] primary_mode;
    logic [1:0] switch_monitor;
    logic [1:0] cur;
    logic [1:0] nxt;
    logic keep_on;
    logic fail_flag;
    logic swreq;
    logic [3:0] trim;
    osc_switch_pkg::key_t lo_key;
    osc_switch_pkg::key_t hi_key;
    logic [7:0] sw_cnt;
    logic trap;
    logic [31:0] prdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic setup;
  logic access;
  logic ctrl_hit;
  logic trim_hit;
  logic mon_en;
  logic sw_en;
  logic fail_cond;
  logic lo_write;
  logic hi_write;
  logic [31:0] rd_word;

  // Advance an unlock sequence by one finished bus transfer
  function automatic osc_switch_pkg::key_t key_step(
    input osc_switch_pkg::key_t k,
    input logic key_write,
    input logic [7:0] d,
    input logic [7:0] k1,
    input logic [7:0] k2
  );
    osc_switch_pkg::key_t r;
    r = osc_switch_pkg::KEY_IDLE;
    if (key_write && k != osc_switch_pkg::KEY_OPEN) begin
      if (k == osc_switch_pkg::KEY_HALF && d == k2) begin
        r = osc_switch_pkg::KEY_OPEN;
      end else if (d == k1) begin
        r = osc_switch_pkg::KEY_HALF;
      end
    end
    return r;
  endfunction

  // Bus decode; every access phase completes at once
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign ctrl_hit = i_paddr == osc_switch_pkg::CTRL_OFFSET;
  assign trim_hit = i_paddr == osc_switch_pkg::TRIM_OFFSET;
  assign o_pready = access;
  assign o_pslverr = access && !ctrl_hit && !trim_hit;
  assign o_prdata = st_reg.prdata;

  // Configuration decode
  assign mon_en = st_reg.switch_monitor == osc_switch_pkg::MONITOR_ON_CFG;
  assign sw_en = !st_reg.switch_monitor[osc_switch_pkg::SWITCH_OFF_CFG_BIT];

  // Only one bus transfer fits in an open window
  assign lo_write = access && i_pwrite && ctrl_hit && i_pstrb[0]
    && st_reg.lo_key == osc_switch_pkg::KEY_OPEN; // [R20] [R22]
  assign hi_write = access && i_pwrite && ctrl_hit && i_pstrb[1]
    && st_reg.hi_key == osc_switch_pkg::KEY_OPEN; // [R21] [R22]

  // Failure: running clock lost, or not started when the delay ends
  assign fail_cond = mon_en && st_reg.sync2[SYNC_POWER_UP] // [R13]
    && st_reg.cur != osc_switch_pkg::GRP_FAST
    && (st_reg.sync2[SYNC_FAIL] || !st_reg.sync2[SYNC_READY]);

  // Read word assembly
  always_comb begin
    rd_word = 32'h0;
    if (ctrl_hit) begin
      rd_word[osc_switch_pkg::CTRL_SWREQ_BIT] = st_reg.swreq;
      rd_word[osc_switch_pkg::CTRL_KEEP_ON_BIT] = st_reg.keep_on;
      rd_word[osc_switch_pkg::CTRL_FAIL_BIT] = st_reg.fail_flag;
      rd_word[osc_switch_pkg::CTRL_LOCK_BIT] = st_reg.sync2[SYNC_LOCK]; // [R4] [R5]
      rd_word[osc_switch_pkg::CTRL_NEXT_LSB +: 2] = st_reg.nxt;
      rd_word[osc_switch_pkg::CTRL_CUR_LSB +: 2] = st_reg.cur; // [R15]
    end else if (trim_hit) begin
      rd_word[osc_switch_pkg::TRIM_LSB +: 4] = st_reg.trim;
    end
  end

  // Next state: sync, bus, switch engine, then failure on top
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = {i_power_up_done, i_osc_ready, i_pll_lock, i_clock_fail};
    st_next.sync2 = st_reg.sync1;
    st_next.trap = 1'b0;
    if (setup) begin
      st_next.prdata = rd_word;
    end
    // Any transfer that is not the next key breaks a sequence
    if (access) begin
      st_next.lo_key = key_step(st_reg.lo_key,
        i_pwrite && ctrl_hit && i_pstrb == osc_switch_pkg::LOW_LANE_ONLY,
        i_pwdata[7:0], osc_switch_pkg::LOW_KEY_FIRST,
        osc_switch_pkg::LOW_KEY_SECOND); // [R20] [R22]
      st_next.hi_key = key_step(st_reg.hi_key,
        i_pwrite && ctrl_hit && i_pstrb == osc_switch_pkg::HIGH_LANE_ONLY,
        i_pwdata[15:8], osc_switch_pkg::HIGH_KEY_FIRST,
        osc_switch_pkg::HIGH_KEY_SECOND); // [R21] [R22]
      if (i_pwrite && trim_hit && i_pstrb[0]) begin
        st_next.trim = i_pwdata[osc_switch_pkg::TRIM_LSB +: 4]; // [R7]
      end
    end
    // Switch engine runs on the registered request
    if (!sw_en) begin
      st_next.cur = st_reg.reset_group; // [R17] [R18]
      st_next.swreq = 1'b0;
      st_next.sw_cnt = 8'h0;
    end else if (st_reg.swreq) begin
      if (st_reg.sw_cnt == 8'(osc_switch_pkg::SWITCH_CYCLES - 1)) begin
        st_next.cur = st_reg.nxt; // [R14] [R16]
        st_next.swreq = 1'b0;
        st_next.sw_cnt = 8'h0;
      end else begin
        st_next.sw_cnt = st_reg.sw_cnt + 8'h1;
      end
    end else begin
      st_next.sw_cnt = 8'h0; // Aborted or idle
    end
    // Unlocked writes; clearing the request aborts a switch
    if (lo_write) begin
      st_next.keep_on = i_pwdata[osc_switch_pkg::CTRL_KEEP_ON_BIT];
      st_next.swreq = sw_en && i_pwdata[osc_switch_pkg::CTRL_SWREQ_BIT]; // [R16]
      if (!i_pwdata[osc_switch_pkg::CTRL_FAIL_BIT]) begin
        st_next.fail_flag = 1'b0;
      end
    end
    if (hi_write) begin
      st_next.nxt = i_pwdata[osc_switch_pkg::CTRL_NEXT_LSB +: 2]; // [R15]
    end
    // Failure wins over request and fail-flag writes in the same cycle
    if (fail_cond) begin
      st_next.cur = osc_switch_pkg::GRP_FAST; // [R11] [R13]
      st_next.fail_flag = 1'b1;
      st_next.swreq = 1'b0;
      st_next.sw_cnt = 8'h0;
      st_next.trap = 1'b1;
    end
    // Synchronous reset loads the configuration bits
    if (!i_rst_n) begin
      st_next = '0;
      st_next.reset_group = i_reset_group_cfg;
      st_next.primary_mode = i_primary_mode_cfg;
      st_next.switch_monitor = i_switch_monitor_cfg;
      st_next.cur = i_reset_group_cfg; // [R15]
      st_next.nxt = i_reset_group_cfg;
      st_next.keep_on = osc_switch_pkg::KEEP_ON_RESET;
      st_next.trim = osc_switch_pkg::TRIM_RESET;
      st_next.lo_key = osc_switch_pkg::KEY_IDLE;
      st_next.hi_key = osc_switch_pkg::KEY_IDLE;
    end
  end

  // All state in one register
  always_ff @(posedge i_clock) begin
    st_reg <= st_next;
  end

  // Secondary crystal control, independent of Sleep
  assign o_secondary_osc_on = st_reg.keep_on; // [R1]
  assign o_use_secondary = st_reg.cur == osc_switch_pkg::GRP_SECONDARY
    && st_reg.keep_on; // [R2]
  assign o_clock_group = st_reg.cur;
  assign o_primary_mode = st_reg.primary_mode; // [R14]

  // PLL gain from the primary mode; only in the primary group
  always_comb begin
    o_pll_gain = osc_switch_pkg::PLL_OFF;
    if (st_reg.cur == osc_switch_pkg::GRP_PRIMARY) begin
      case (st_reg.primary_mode[2:0])
        osc_switch_pkg::PLL_X4_MODE: o_pll_gain = osc_switch_pkg::PLL_X4; // [R3]
        osc_switch_pkg::PLL_X8_MODE: o_pll_gain = osc_switch_pkg::PLL_X8;
        osc_switch_pkg::PLL_X16_MODE: o_pll_gain = osc_switch_pkg::PLL_X16;
        default: o_pll_gain = osc_switch_pkg::PLL_OFF;
      endcase
    end
  end
  assign o_pll_enable = o_pll_gain != osc_switch_pkg::PLL_OFF;
  assign o_pll_locked = st_reg.sync2[SYNC_LOCK]; // [R4]

  // Fast RC runs whenever it is the current group
  assign o_fast_rc_on = st_reg.cur == osc_switch_pkg::GRP_FAST; // [R6]
  assign o_fast_rc_trim = st_reg.trim; // [R7]

  // Slow RC: on through power-up, then only while something needs it;
  // failure only drops the slow group term, so the watchdog keeps counting
  assign o_slow_rc_on = !st_reg.sync2[SYNC_POWER_UP] // [R8] [R9]
    || (mon_en && !i_sleep) // [R10]
    || i_watchdog_cfg_enable || i_soft_watchdog_enable // [R12]
    || st_reg.cur == osc_switch_pkg::GRP_SLOW;

  assign o_fail_trap = st_reg.trap; // [R11]

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  a_secondary_sleep: assert property ( // [R1]
    i_sleep && st_reg.keep_on |-> o_secondary_osc_on)
    else $error("secondary crystal off while kept on");
  a_secondary_use: assert property ( // [R2]
    o_use_secondary |-> o_clock_group == 2'h0 && o_secondary_osc_on)
    else $error("secondary used outside its group");
  a_pll_sixteen: assert property ( // [R3]
    st_reg.cur == osc_switch_pkg::GRP_PRIMARY && st_reg.primary_mode[2:0] == 3'h7
    |-> o_pll_gain == osc_switch_pkg::PLL_X16 && o_pll_enable)
    else $error("pll gain not sixteen");
  a_lock_read: assert property ( // [R5]
    setup && ctrl_hit |=> o_prdata[5] == $past(st_reg.sync2[SYNC_LOCK]))
    else $error("lock bit not mirrored");
  a_fast_rc_run: assert property ( // [R6]
    o_clock_group == 2'h1 |-> o_fast_rc_on)
    else $error("fast rc off in its group");
  a_slow_rc_power: assert property ( // [R8]
    !st_reg.sync2[SYNC_POWER_UP] |-> o_slow_rc_on)
    else $error("slow rc off before delay end");
  a_slow_rc_monitor: assert property ( // [R10]
    mon_en && !i_sleep |-> o_slow_rc_on)
    else $error("slow rc off with monitor enabled");
  a_fail_fallback: assert property ( // [R11]
    fail_cond |=> o_clock_group == 2'h1 && st_reg.fail_flag && !st_reg.swreq
    && o_fail_trap ##1 !o_fail_trap)
    else $error("failure fallback wrong");
  a_switch_locked: assert property ( // [R17]
    st_reg.switch_monitor[1]
    |=> !st_reg.swreq && st_reg.cur == st_reg.reset_group && !fail_cond)
    else $error("switching not disabled");
  a_locked_ignore: assert property ( // [R22]
    access && i_pwrite && ctrl_hit && st_reg.lo_key != osc_switch_pkg::KEY_OPEN
    |=> st_reg.keep_on == $past(st_reg.keep_on))
    else $error("locked low byte was written");
  a_low_first: assert property ( // [R20]
    access && i_pwrite && ctrl_hit && i_pstrb == osc_switch_pkg::LOW_LANE_ONLY
    && i_pwdata[7:0] == osc_switch_pkg::LOW_KEY_FIRST
    && st_reg.lo_key != osc_switch_pkg::KEY_OPEN
    |=> st_reg.lo_key == osc_switch_pkg::KEY_HALF)
    else $error("low byte first key not taken");
  a_low_unlock: assert property ( // [R20]
    access && i_pwrite && ctrl_hit && i_pstrb == osc_switch_pkg::LOW_LANE_ONLY
    && i_pwdata[7:0] == osc_switch_pkg::LOW_KEY_SECOND
    && st_reg.lo_key == osc_switch_pkg::KEY_HALF
    |=> st_reg.lo_key == osc_switch_pkg::KEY_OPEN)
    else $error("low byte unlock failed");
  a_window_once: assert property ( // [R22]
    access && st_reg.lo_key == osc_switch_pkg::KEY_OPEN
    |=> st_reg.lo_key == osc_switch_pkg::KEY_IDLE)
    else $error("low byte window left open");
  a_high_unlock: assert property ( // [R21]
    hi_write |=> st_reg.nxt == $past(i_pwdata[9:8])
    && st_reg.hi_key == osc_switch_pkg::KEY_IDLE)
    else $error("high byte write not taken once");
  a_trap_cause: assert property ( // [R11]
    !fail_cond |=> !o_fail_trap)
    else $error("trap without failure");
  a_slow_rc_idle: assert property ( // [R9]
    st_reg.sync2[SYNC_POWER_UP] && !mon_en && !i_watchdog_cfg_enable
    && !i_soft_watchdog_enable && st_reg.cur != osc_switch_pkg::GRP_SLOW
    |-> !o_slow_rc_on)
    else $error("slow rc left on unneeded");
  a_trim_write: assert property ( // [R7]
    access && i_pwrite && trim_hit && i_pstrb[0]
    |=> o_fast_rc_trim == $past(i_pwdata[3:0]))
    else $error("trim write not taken");

  c_fail_trap: cover property (fail_cond ##1 o_fail_trap);
  c_switch_done: cover property (st_reg.swreq ##1 !st_reg.swreq && !fail_cond);
  c_high_write: cover property (hi_write);
  c_abort: cover property (st_reg.swreq && lo_write && !i_pwdata[0]);

endmodule

// *** osc_switch_pkg.sv ***
package osc_switch_pkg;

  // Register byte offsets on the bus
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] TRIM_OFFSET = 12'h004;

  // Control register field positions
  localparam int CTRL_SWREQ_BIT = 0;
  localparam int CTRL_KEEP_ON_BIT = 1;
  localparam int CTRL_FAIL_BIT = 3;
  localparam int CTRL_LOCK_BIT = 5;
  localparam int CTRL_NEXT_LSB = 8;
  localparam int CTRL_CUR_LSB = 12;
  localparam int TRIM_LSB = 0;

  // Reset values of software state
  localparam logic [3:0] TRIM_RESET = 4'h0;
  localparam logic KEEP_ON_RESET = 1'b0;

  // Unlock keys, per byte of the control register
  localparam logic [7:0] LOW_KEY_FIRST = 8'h46;
  localparam logic [7:0] LOW_KEY_SECOND = 8'h57;
  localparam logic [7:0] HIGH_KEY_FIRST = 8'h78;
  localparam logic [7:0] HIGH_KEY_SECOND = 8'h9a;

  // Byte-lane strobes that count as a single byte write
  localparam logic [3:0] LOW_LANE_ONLY = 4'h1;
  localparam logic [3:0] HIGH_LANE_ONLY = 4'h2;

  // Clock switch settle time
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int SWITCH_TIME_NS = 2000;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Switch and monitor configuration encodings
  localparam logic [1:0] MONITOR_ON_CFG = 2'h0;
  localparam int SWITCH_OFF_CFG_BIT = 1;

  // Clock groups
  typedef enum logic [1:0] {
    GRP_SECONDARY = 2'h0,
    GRP_FAST = 2'h1,
    GRP_SLOW = 2'h2,
    GRP_PRIMARY = 2'h3
  } clock_group_t;

  // Multiplier codes in the low bits of the primary mode
  localparam logic [2:0] PLL_X4_MODE = 3'h5;
  localparam logic [2:0] PLL_X8_MODE = 3'h6;
  localparam logic [2:0] PLL_X16_MODE = 3'h7;

  typedef enum logic [1:0] {
    PLL_OFF = 2'h0,
    PLL_X4 = 2'h1,
    PLL_X8 = 2'h3,
    PLL_X16 = 2'h2
  } pll_gain_t;

  // Unlock sequence states, Gray along the path
  typedef enum logic [1:0] {
    KEY_IDLE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OPEN = 2'h3
  } key_t;

endpackage

// *** osc_source_model.sv ***
`timescale 1ns/1ps

// Oscillator sources with a power-up delay and a start-up time
module osc_source_model #(
  parameter int DELAY = 8,
  parameter int START = 4
) (
  // Clock, reset and test controls
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_slow_start,
  input wire logic i_break,
  input wire logic i_pll_enable,
  // Oscillator status
  output logic o_osc_ready,
  output logic o_pll_lock,
  output logic o_clock_fail,
  output logic o_delay_done
);
  logic [7:0] age_reg;

  // Age since reset, saturating so readiness never wraps away
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      age_reg <= 8'h0;
    end else if (age_reg != 8'hff) begin
      age_reg <= age_reg + 8'h1;
    end
  end

  // A slow start outlasts the power-up delay on purpose
  assign o_delay_done = age_reg >= 8'(DELAY);
  assign o_osc_ready = !i_break && age_reg >= (i_slow_start ? 8'hc8 : 8'(START));
  assign o_pll_lock = i_pll_enable && o_osc_ready && age_reg >= 8'(START + 2);
  assign o_clock_fail = i_break;
endmodule

// *** oscillator_switch_and_fail_monitor_test.sv ***
`timescale 1ns/1ps

module oscillator_switch_and_fail_monitor_test;
  logic clk;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwd = 32'h0;
  logic [3:0] pst = 4'h0;
  logic [1:0] smc = 2'h0;
  logic [1:0] grp = 2'h3;
  logic [3:0] mode = 4'h7;
  logic sleep = 1'h0;
  logic swd = 1'h0;
  logic slow = 1'h0;
  logic brk = 1'h0;
  logic wdc = 1'h0;
  logic [31:0] prd, rd;
  logic pready, perr, err, fail, lock, ready, up_done, pll_en;
  logic sec_on, use_sec, pll_lk, fast_on, trap, slow_on;
  logic [1:0] cur;
  logic [3:0] pmode, trim;
  osc_switch_pkg::pll_gain_t gain;
  int n_mismatch = 0;
  int checked = 0;

  oscillator_switch_and_fail_monitor oscillator_switch_and_fail_monitor_inst (
    .i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwd), .i_pstrb(pst), .o_prdata(prd), .o_pready(pready),
    .o_pslverr(perr), .i_reset_group_cfg(grp), .i_primary_mode_cfg(mode),
    .i_switch_monitor_cfg(smc), .i_watchdog_cfg_enable(wdc), .i_sleep(sleep),
    .i_soft_watchdog_enable(swd), .i_clock_fail(fail), .i_pll_lock(lock),
    .i_osc_ready(ready), .i_power_up_done(up_done), .o_secondary_osc_on(sec_on),
    .o_use_secondary(use_sec), .o_clock_group(cur), .o_primary_mode(pmode),
    .o_pll_enable(pll_en), .o_pll_gain(gain), .o_pll_locked(pll_lk), .o_fast_rc_on(fast_on),
    .o_fast_rc_trim(trim), .o_slow_rc_on(slow_on), .o_fail_trap(trap));

  osc_source_model osc_source_model_inst (
    .i_clock(clk), .i_rst_n(rst_n), .i_slow_start(slow), .i_break(brk),
    .i_pll_enable(pll_en), .o_osc_ready(ready), .o_pll_lock(lock), .o_clock_fail(fail),
    .o_delay_done(up_done));

  // 10 MHz clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; the idle edge before it keeps drives one per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    pst <= s;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1); // A hang is left to the watchdog
    rd = prd;
    err = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string m);
    apb(1'h0, a, 32'h0, 4'h0);
    chk(rd, e, m);
  endtask

  // Key pair then the protected byte write
  task automatic ctl(input logic hi, input logic [7:0] v);
    apb(1'h1, 12'h0, hi ? 32'h7800 : 32'h46, hi ? 4'h2 : 4'h1);
    apb(1'h1, 12'h0, hi ? 32'h9a00 : 32'h57, hi ? 4'h2 : 4'h1);
    apb(1'h1, 12'h0, hi ? {16'h0, v, 8'h0} : {24'h0, v}, hi ? 4'h2 : 4'h1);
  endtask

  task automatic rst(input logic [1:0] sm, input logic [1:0] rg, input logic [3:0] pm);
    @(posedge clk);
    rst_n <= 1'h0;
    smc <= sm;
    grp <= rg;
    mode <= pm;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    chk(slow_on, 1'h1, "slow rc at power-up");
  endtask

  task automatic wait_grp(input logic [1:0] g);
    for (int n = 0; n < 40 && cur !== g; n++) @(posedge clk);
    chk(cur, g, "group reached");
  endtask

  task automatic t_reset();
    osc_switch_pkg::pll_gain_t g[3];
    g = '{osc_switch_pkg::PLL_X4, osc_switch_pkg::PLL_X8, osc_switch_pkg::PLL_X16};
    for (int i = 0; i < 3; i++) begin
      rst(2'h0, 2'h3, 4'h5 + 4'(i));
      repeat (15) @(negedge clk);
      chk(gain, g[i], "pll gain");
      chk(pmode, 4'h5 + 4'(i), "primary mode");
    end
    chk(pll_lk, 1'h1, "lock");
    rchk(12'h0, 32'h3320, "ctrl reset");
    rchk(12'h4, 32'h0, "trim reset");
    $display("test reset done");
  endtask

  task automatic t_lock();
    apb(1'h1, 12'h0, 32'h2, 4'h1);
    rchk(12'h0, 32'h3320, "locked write");
    apb(1'h1, 12'h0, 32'h46, 4'h1);
    rchk(12'h4, 32'h0, "trim");
    apb(1'h1, 12'h0, 32'h57, 4'h1);
    apb(1'h1, 12'h0, 32'h2, 4'h1);
    rchk(12'h0, 32'h3320, "broken keys");
    ctl(1'h0, 8'h2);
    rchk(12'h0, 32'h3322, "keep on");
    chk(sec_on, 1'h1, "secondary on");
    $display("test unlock done");
  endtask

  task automatic t_switch();
    rst(2'h1, 2'h3, 4'h7); // Monitor off before any slow clock
    ctl(1'h1, 8'h1);
    ctl(1'h0, 8'h3);
    rchk(12'h0, 32'h3123, "request");
    wait_grp(2'h1);
    repeat (4) @(negedge clk);
    chk(fast_on, 1'h1, "fast rc");
    chk(pll_en, 1'h0, "pll off");
    rchk(12'h0, 32'h1102, "switched");
    ctl(1'h1, 8'h0);
    ctl(1'h0, 8'h3);
    ctl(1'h0, 8'h2);
    repeat (30) @(posedge clk);
    chk(cur, 2'h1, "abort");
    ctl(1'h0, 8'h3);
    wait_grp(2'h0);
    @(negedge clk);
    chk(use_sec, 1'h1, "secondary clock");
    $display("test switch done");
  endtask

  task automatic t_fail();
    rst(2'h0, 2'h3, 4'h7);
    ctl(1'h0, 8'h2);
    @(posedge clk);
    brk <= 1'h1;
    for (int n = 0; n < 10 && trap !== 1'h1; n++) @(posedge clk);
    chk(trap, 1'h1, "trap");
    @(posedge clk);
    brk <= 1'h0;
    chk(trap, 1'h0, "trap width");
    @(negedge clk);
    chk(cur, 2'h1, "fallback");
    chk(slow_on, 1'h1, "watchdog clock");
    rchk(12'h0, 32'h130a, "fail flag");
    sleep <= 1'h1;
    repeat (2) @(negedge clk);
    chk(slow_on, 1'h0, "slow rc asleep");
    chk(sec_on, 1'h1, "secondary asleep");
    @(posedge clk);
    sleep <= 1'h0;
    ctl(1'h0, 8'h2);
    rchk(12'h0, 32'h1302, "flag clear");
    $display("test failure done");
  endtask

  task automatic t_trim();
    logic [3:0] v[4];
    v = '{4'h7, 4'h8, 4'hf, 4'h0};
    foreach (v[i]) begin
      apb(1'h1, 12'h4, {28'h0, v[i]}, 4'h1);
      rchk(12'h4, {28'h0, v[i]}, "trim");
      chk(trim, v[i], "trim out");
    end
    apb(1'h0, 12'h8, 32'h0, 4'h0);
    chk(err, 1'h1, "unmapped");
    $display("test trim done");
  endtask

  task automatic t_slow();
    @(posedge clk);
    slow <= 1'h1;
    rst(2'h0, 2'h3, 4'h7);
    for (int n = 0; n < 30 && trap !== 1'h1; n++) @(posedge clk);
    chk(trap, 1'h1, "late start trap");
    @(negedge clk);
    chk(cur, 2'h1, "late start group");
    @(posedge clk);
    slow <= 1'h0;
    $display("test late start done");
  endtask

  task automatic t_nosw();
    int n;
    n = 0;
    rst(2'h2, 2'h3, 4'h7);
    repeat (15) @(negedge clk);
    chk(slow_on, 1'h0, "slow rc stopped");
    @(posedge clk);
    wdc <= 1'h1;
    @(negedge clk);
    chk(slow_on, 1'h1, "watchdog cfg");
    @(posedge clk);
    wdc <= 1'h0;
    ctl(1'h0, 8'h1);
    rchk(12'h0, 32'h3320, "no request");
    brk <= 1'h1;
    repeat (10) begin
      @(posedge clk);
      n += (trap === 1'h1);
    end
    brk <= 1'h0;
    swd <= 1'h1;
    chk(n, 0, "no monitor");
    chk(cur, 2'h3, "cfg group");
    @(negedge clk);
    chk(slow_on, 1'h1, "soft watchdog");
    $display("test no switching done");
  endtask

  task automatic test_done();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_lock();
    t_switch();
    t_fail();
    t_trim();
    t_slow();
    t_nosw();
    test_done();
  end

  // Tests need about four hundred cycles; allow fifty times that
  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end
endmodule
